// ==== core/ipc_pkg.sv ====
// package for the paged two-wire control port: address, registers, checksum constants
// assumes both ends compile against it before the interface and modules
package ipc_pkg;
   localparam logic [4:0] IPC_ADDR_HI = 5'h13; // fixed upper address bits 10011
   localparam logic [7:0] IPC_REG_PAGE = 8'h00;
   localparam logic [7:0] IPC_REG_XOR = 8'h7d;
   localparam logic [7:0] IPC_REG_CRC = 8'h7e;
   localparam logic [7:0] IPC_REG_BOOK = 8'h7f;
   localparam logic [7:0] IPC_BOOK_CSUM = 8'h8c;
   localparam logic [7:0] IPC_BOOK_BIQUAD = 8'haa;
   localparam logic [7:0] IPC_PAGE_ZERO = 8'h00;
   localparam logic [7:0] IPC_CRC_POLY = 8'h07;
   localparam logic [7:0] IPC_RST_VAL = 8'h00;
   // controller software port offsets
   localparam logic [3:0] IPC_CMD_ADDR = 4'h0; // target address bits
   localparam logic [3:0] IPC_CMD_SUB = 4'h1; // sub-address
   localparam logic [3:0] IPC_CMD_DATA = 4'h2; // write data, unused for reads
   localparam logic [3:0] IPC_CMD_GO = 4'h3; // bit0 1=read, starts transfer
   localparam logic [3:0] IPC_CMD_STAT = 4'h4; // bit0 busy, bit1 nack seen
   localparam logic [3:0] IPC_CMD_RDATA = 4'h5; // last byte read
   // link timing: 100 kHz scl from a 10 MHz clock, quarter period enable
   localparam int IPC_CLK_HZ = 10000000;
   localparam int IPC_SCL_HZ = 100000;
   localparam int IPC_QTR_CYC = IPC_CLK_HZ / (IPC_SCL_HZ * 4);
   localparam logic [7:0] IPC_QTR_CNT = 8'(IPC_QTR_CYC - 1);
endpackage

// ==== core/ipc_link_if.sv ====
// interface joining the controller end and the target end of the two-wire link
// assumes open-drain lines pulled high when nobody drives
`timescale 1ns/1ns
interface ipc_link_if;
   logic scl_o_ctl;
   logic scl_oe_ctl;
   logic sda_o_ctl;
   logic sda_oe_ctl;
   logic sda_o_tgt;
   logic sda_oe_tgt;
   wire scl;
   wire sda;
   // wired-and of the open-drain drivers
   assign scl = ~(scl_oe_ctl & ~scl_o_ctl);
   assign sda = ~((sda_oe_ctl & ~sda_o_ctl) | (sda_oe_tgt & ~sda_o_tgt));
   modport ctl (output scl_o_ctl, output scl_oe_ctl, output sda_o_ctl, output sda_oe_ctl,
      input scl, input sda);
   modport tgt (output sda_o_tgt, output sda_oe_tgt, input scl, input sda);
endinterface

// ==== core/ipc_target.sv ====
// target end: two-wire address match, paged registers, crc and xor checksums
// assumes scl and sda come from another domain and are synchronised here
//
// Design decision made here: the plain strobed port.
`timescale 1ns/1ns
module ipc_target (
   // clock and reset
   input wire logic clk_i,
   input wire logic reset_i,
   // strap: low two address bits from the resistor decoder
   input wire logic [1:0] addr_strap_i,
   // link
   ipc_link_if.tgt link,
   // state seen by the system
   output logic [7:0] page_o,
   output logic [7:0] book_o,
   output logic [7:0] crc_o,
   output logic [7:0] xor_o,
   output logic wr_stb_o,
   output logic [7:0] wr_addr_o,
   output logic [7:0] wr_data_o
);
   import ipc_pkg::*;

   typedef enum logic [2:0] {
      IPC_T_IDLE = 3'b000,
      IPC_T_ADDR = 3'b001,
      IPC_T_SUB = 3'b010,
      IPC_T_WDAT = 3'b011,
      IPC_T_RDAT = 3'b100,
      IPC_T_ACK = 3'b101,
      IPC_T_RACK = 3'b110
   } ipc_tstate_t;

   // one crc step over a whole byte, msb first, no reflection
   function automatic logic [7:0] ipc_crc8(input logic [7:0] c, input logic [7:0] d);
      logic [7:0] r;
      r = c ^ d;
      for (int i = 0; i < 8; i++) begin
         r = r[7] ? ((r << 1) ^ IPC_CRC_POLY) : (r << 1);
      end
      return r;
   endfunction

   logic [1:0] scl_s_r, sda_s_r;
   logic scl_d_r, sda_d_r;
   logic [1:0] strap_s_r, strap_r;
   ipc_tstate_t st_r, ret_r;
   logic [3:0] bit_r;
   logic [7:0] sh_r;
   logic [7:0] sub_r;
   logic [7:0] page_r, book_r, crc_r, xor_r;
   logic sda_oe_r;
   logic wr_stb_r;
   logic [7:0] wr_addr_r, wr_data_r;

   // two-flop synchronisers plus a delayed copy; the second stage and its copy are read
   always_ff @(posedge clk_i) begin
      scl_s_r <= {scl_s_r[0], link.scl};
      sda_s_r <= {sda_s_r[0], link.sda};
      scl_d_r <= scl_s_r[1];
      sda_d_r <= sda_s_r[1];
   end

   // line events
   wire scl_h = scl_s_r[1];
   wire sda_h = sda_s_r[1];
   wire scl_rise = scl_h & ~scl_d_r;
   wire scl_fall = ~scl_h & scl_d_r;
   wire start_ev = scl_h & scl_d_r & ~sda_h & sda_d_r;
   wire stop_ev = scl_h & scl_d_r & sda_h & ~sda_d_r;
   wire [7:0] byte_in = {sh_r[6:0], sda_h};
   wire addr_hit = (sh_r[7:1] == {IPC_ADDR_HI, strap_r});
   wire on_pg0 = (page_r == IPC_PAGE_ZERO);
   wire in_csum = on_pg0 & (book_r == IPC_BOOK_CSUM);
   wire is_page_wr = (sub_r == IPC_REG_PAGE);
   wire is_book_wr = on_pg0 & (sub_r == IPC_REG_BOOK);
   wire is_crc_wr = in_csum & (sub_r == IPC_REG_CRC);
   wire is_xor_wr = in_csum & (sub_r == IPC_REG_XOR);
   wire xor_counts = (book_r == IPC_BOOK_CSUM) & ~on_pg0;
   wire [7:0] rd_byte = ~on_pg0 ? 8'h00 :
      (sub_r == IPC_REG_PAGE) ? page_r :
      (sub_r == IPC_REG_BOOK) ? book_r :
      in_csum && sub_r == IPC_REG_CRC ? crc_r :
      in_csum && sub_r == IPC_REG_XOR ? xor_r : 8'h00;
   wire data_wr = (st_r == IPC_T_WDAT) & scl_rise & (bit_r == 4'h7);

   // strap pin passes two flops before the address match reads it
   always_ff @(posedge clk_i) begin
      strap_s_r <= addr_strap_i;
      strap_r <= strap_s_r;
   end

   // serial state machine; bits sampled on rising scl, driven on falling
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         st_r <= IPC_T_IDLE;
         ret_r <= IPC_T_IDLE;
         bit_r <= 4'h0;
         sh_r <= 8'h00;
         sub_r <= 8'h00;
         sda_oe_r <= 1'b0;
      end else if (start_ev) begin
         st_r <= IPC_T_ADDR; // repeated start keeps sub-address
         bit_r <= 4'h0;
         sda_oe_r <= 1'b0;
      end else if (stop_ev) begin
         st_r <= IPC_T_IDLE;
         sda_oe_r <= 1'b0;
      end else begin
         case (st_r)
            IPC_T_ADDR, IPC_T_SUB, IPC_T_WDAT: begin
               if (scl_rise) begin
                  sh_r <= byte_in;
                  bit_r <= bit_r + 4'h1;
               end
               if (scl_fall && bit_r == 4'h8) begin
                  bit_r <= 4'h0;
                  if (st_r == IPC_T_ADDR && !addr_hit) begin
                     st_r <= IPC_T_IDLE;
                  end else begin
                     sda_oe_r <= 1'b1; // ack pulls sda low
                     st_r <= IPC_T_ACK;
                     if (st_r == IPC_T_ADDR) begin
                        ret_r <= sh_r[0] ? IPC_T_RDAT : IPC_T_SUB;
                     end else if (st_r == IPC_T_SUB) begin
                        sub_r <= sh_r;
                        ret_r <= IPC_T_WDAT;
                     end else begin
                        ret_r <= IPC_T_WDAT;
                     end
                  end
               end
            end
            IPC_T_ACK: begin
               if (scl_fall) begin
                  st_r <= ret_r;
                  if (ret_r == IPC_T_RDAT) begin
                     sh_r <= rd_byte;
                     sda_oe_r <= ~rd_byte[7];
                     bit_r <= 4'h1;
                  end else begin
                     sda_oe_r <= 1'b0;
                  end
               end
            end
            IPC_T_RDAT: begin
               if (scl_fall) begin
                  if (bit_r == 4'h8) begin
                     sda_oe_r <= 1'b0; // release for controller ack
                     st_r <= IPC_T_RACK;
                  end else begin
                     sda_oe_r <= ~sh_r[7 - bit_r[2:0]];
                     bit_r <= bit_r + 4'h1;
                  end
               end
            end
            IPC_T_RACK: begin
               if (scl_rise) begin
                  sub_r <= sub_r + 8'h01;
                  st_r <= sda_h ? IPC_T_IDLE : IPC_T_ACK; // nack ends
                  ret_r <= IPC_T_RDAT;
                  bit_r <= 4'h0;
               end
            end
            default: st_r <= IPC_T_IDLE;
         endcase
         if (data_wr) begin
            sub_r <= sub_r + 8'h01;
         end
      end
   end

   // write side effects: page, book, checksums; reads change none
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         page_r <= IPC_RST_VAL;
         book_r <= IPC_RST_VAL;
         crc_r <= IPC_RST_VAL;
         xor_r <= IPC_RST_VAL;
         wr_stb_r <= 1'b0;
         wr_addr_r <= 8'h00;
         wr_data_r <= 8'h00;
      end else begin
         wr_stb_r <= data_wr;
         if (data_wr) begin
            wr_addr_r <= sub_r;
            wr_data_r <= byte_in;
            if (is_page_wr) begin
               page_r <= byte_in;
            end else if (is_book_wr) begin
               book_r <= byte_in;
            end else if (is_crc_wr) begin
               crc_r <= byte_in;
            end else if (is_xor_wr) begin
               xor_r <= byte_in;
            end
            if (!is_page_wr && !is_book_wr && !is_crc_wr) begin
               crc_r <= ipc_crc8(crc_r, byte_in);
            end
            if (xor_counts && !is_page_wr) begin
               xor_r <= xor_r ^ byte_in;
            end
         end
      end
   end

   assign link.sda_o_tgt = 1'b0;
   assign link.sda_oe_tgt = sda_oe_r;
   assign page_o = page_r;
   assign book_o = book_r;
   assign crc_o = crc_r;
   assign xor_o = xor_r;
   assign wr_stb_o = wr_stb_r;
   assign wr_addr_o = wr_addr_r;
   assign wr_data_o = wr_data_r;
endmodule

// ==== core/ipc_ctrl.sv ====
// controller end: software port drives single-byte writes and reads on the link
// assumes target answers on sda; scl is made here by a divider
`timescale 1ns/1ns
module ipc_ctrl (
   // clock and reset
   input wire logic clk_i,
   input wire logic reset_i,
   // software port
   input wire logic [3:0] addr_i,
   input wire logic [7:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [7:0] rdata_o,
   // link
   ipc_link_if.ctl link
);
   import ipc_pkg::*;

   typedef enum logic [2:0] {
      IPC_C_IDLE = 3'b000,
      IPC_C_START = 3'b001,
      IPC_C_BYTE = 3'b010,
      IPC_C_ACK = 3'b011,
      IPC_C_STOP = 3'b100,
      IPC_C_RSTART = 3'b101
   } ipc_cstate_t;

   logic [7:0] div_r;
   logic [1:0] ph_r;
   logic [1:0] sda_s_r;
   ipc_cstate_t st_r;
   logic [6:0] tgt_r;
   logic [7:0] sub_r, dat_r, rx_r, sh_r;
   logic [2:0] idx_r;
   logic [2:0] bit_r;
   logic dir_r, busy_r, nack_r, scl_r, sda_r, rxm_r;
   logic [7:0] rdata_r;

   wire qtr = (div_r == IPC_QTR_CNT);
   wire sda_in = sda_s_r[1];
   // byte sequence: write = addr,sub,data; read = addr,sub,addr|1,rx
   wire [7:0] seq_byte = (idx_r == 3'h0) ? {tgt_r, 1'b0} :
      (idx_r == 3'h1) ? sub_r :
      (idx_r == 3'h2 && !dir_r) ? dat_r :
      (idx_r == 3'h2) ? {tgt_r, 1'b1} : 8'hff;
   wire [7:0] stat = {6'h00, nack_r, busy_r};

   // quarter period divider and sda synchroniser
   always_ff @(posedge clk_i) begin
      sda_s_r <= {sda_s_r[0], link.sda};
      if (reset_i || qtr) begin
         div_r <= 8'h00;
      end else begin
         div_r <= div_r + 8'h01;
      end
   end

   // software registers and read port
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         tgt_r <= 7'h00;
         sub_r <= 8'h00;
         dat_r <= 8'h00;
         rdata_r <= 8'h00;
      end else begin
         if (wr_i && addr_i == IPC_CMD_ADDR) tgt_r <= wdata_i[6:0];
         if (wr_i && addr_i == IPC_CMD_SUB) sub_r <= wdata_i;
         if (wr_i && addr_i == IPC_CMD_DATA) dat_r <= wdata_i;
         rdata_r <= !rd_i ? 8'h00 : (addr_i == IPC_CMD_STAT) ? stat :
            (addr_i == IPC_CMD_RDATA) ? rx_r : 8'h00;
      end
   end

   // link sequencer, one step per quarter period
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         st_r <= IPC_C_IDLE;
         ph_r <= 2'h0;
         idx_r <= 3'h0;
         bit_r <= 3'h0;
         sh_r <= 8'h00;
         rx_r <= 8'h00;
         dir_r <= 1'b0;
         busy_r <= 1'b0;
         nack_r <= 1'b0;
         scl_r <= 1'b1;
         sda_r <= 1'b1;
         rxm_r <= 1'b0;
      end else if (!busy_r) begin
         if (wr_i && addr_i == IPC_CMD_GO) begin
            busy_r <= 1'b1;
            dir_r <= wdata_i[0];
            nack_r <= 1'b0;
            idx_r <= 3'h0;
            rxm_r <= 1'b0;
            st_r <= IPC_C_START;
            ph_r <= 2'h0;
         end
      end else if (qtr) begin
         ph_r <= ph_r + 2'h1;
         case (st_r)
            IPC_C_START, IPC_C_RSTART: begin
               if (ph_r == 2'h0) begin
                  sda_r <= 1'b1;
               end else if (ph_r == 2'h1) begin
                  scl_r <= 1'b1;
               end else if (ph_r == 2'h2) begin
                  sda_r <= 1'b0; // start, or repeated start for read
               end else begin
                  scl_r <= 1'b0;
                  sh_r <= seq_byte;
                  bit_r <= 3'h0;
                  st_r <= IPC_C_BYTE;
               end
            end
            IPC_C_BYTE, IPC_C_ACK: begin
               if (ph_r == 2'h0) begin
                  if (st_r == IPC_C_BYTE) begin
                     sda_r <= rxm_r ? 1'b1 : sh_r[7];
                  end else begin
                     sda_r <= rxm_r ? 1'b1 : 1'b1; // single read: nack last
                  end
               end else if (ph_r == 2'h1) begin
                  scl_r <= 1'b1;
               end else if (ph_r == 2'h2) begin
                  if (st_r == IPC_C_BYTE) begin
                     sh_r <= {sh_r[6:0], sda_in};
                  end else if (!rxm_r && sda_in) begin
                     nack_r <= 1'b1;
                  end
               end else begin
                  scl_r <= 1'b0;
                  if (st_r == IPC_C_BYTE) begin
                     bit_r <= bit_r + 3'h1;
                     if (bit_r == 3'h7) st_r <= IPC_C_ACK;
                  end else if (rxm_r) begin
                     rx_r <= sh_r;
                     st_r <= IPC_C_STOP;
                  end else if (nack_r || (idx_r == 3'h2 && !dir_r)) begin
                     st_r <= IPC_C_STOP;
                  end else if (idx_r == 3'h1 && dir_r) begin
                     idx_r <= 3'h2;
                     st_r <= IPC_C_RSTART;
                  end else if (idx_r == 3'h2) begin
                     rxm_r <= 1'b1;
                     sh_r <= 8'hff;
                     bit_r <= 3'h0;
                     st_r <= IPC_C_BYTE;
                  end else begin
                     idx_r <= idx_r + 3'h1;
                     sh_r <= (idx_r == 3'h0) ? sub_r : dat_r;
                     bit_r <= 3'h0;
                     st_r <= IPC_C_BYTE;
                  end
               end
            end
            IPC_C_STOP: begin
               if (ph_r == 2'h0) begin
                  sda_r <= 1'b0;
               end else if (ph_r == 2'h1) begin
                  scl_r <= 1'b1;
               end else if (ph_r == 2'h2) begin
                  sda_r <= 1'b1; // stop ends the transfer
               end else begin
                  busy_r <= 1'b0;
                  st_r <= IPC_C_IDLE;
               end
            end
            default: st_r <= IPC_C_IDLE;
         endcase
      end
   end

   assign link.scl_o_ctl = 1'b0;
   assign link.scl_oe_ctl = ~scl_r;
   assign link.sda_o_ctl = 1'b0;
   assign link.sda_oe_ctl = ~sda_r;
   assign rdata_o = rdata_r;
endmodule

// ==== verification/ipc_link_chk_sva.sv ====
// checker for the two-wire link joining the controller end and the target end
// assumes one clock domain and the bench instantiating it beside the link interface
`timescale 1ns/1ns
module ipc_link_chk (
   // clock and reset
   input wire logic clk_i,
   input wire logic reset_i,
   // resolved lines
   input wire scl,
   input wire sda,
   // drivers
   input wire logic scl_oe_ctl,
   input wire logic sda_oe_ctl,
   input wire logic sda_o_tgt,
   input wire logic sda_oe_tgt
);
   logic scl_q;
   logic sda_q;
   logic [3:0] bit_cnt;
   // who pulls sda low, and when scl rises
   wire tgt_drv = sda_oe_tgt & ~sda_o_tgt;
   wire ctl_drv = sda_oe_ctl;
   wire scl_up = scl & ~scl_q;
   wire is_start = scl & scl_q & sda_q & ~sda;
   // scl rises since the last start, in nine-bit units
   always_ff @(posedge clk_i) begin
      scl_q <= scl;
      sda_q <= sda;
      if (reset_i) begin
         bit_cnt <= 4'h1;
      end else if (is_start) begin
         bit_cnt <= 4'h0;
      end else if (scl_up) begin
         bit_cnt <= (bit_cnt == 4'h8) ? 4'h0 : bit_cnt + 4'h1;
      end
   end

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (reset_i);

   sequence seq_start;
      scl && scl_q && sda_q && !sda;
   endsequence
   sequence seq_stop;
      scl && scl_q && !sda_q && sda;
   endsequence

   // a whole number of nine-bit units lies between framing conditions
   chk_start_framing: assert property (seq_start |-> bit_cnt == 4'h1)
      else $error("start in the middle of a byte");
   chk_stop_framing: assert property (seq_stop |-> bit_cnt == 4'h1 && !tgt_drv)
      else $error("stop in the middle of a byte or while target drives");
   // clock phases keep the slow-mode shape
   chk_scl_high_min: assert property ($rose(scl) |-> scl [*8])
      else $error("scl high phase too short");
   chk_scl_low_min: assert property ($fell(scl) |-> !scl [*8])
      else $error("scl low phase too short");
   // target changes sda only while scl is low and lets go again
   chk_tgt_steady_high: assert property (scl && scl_q |-> $stable(tgt_drv))
      else $error("target moved sda while scl high");
   chk_tgt_starts_low: assert property ($rose(tgt_drv) |-> !scl)
      else $error("target began driving with scl high");
   chk_tgt_release: assert property ($rose(tgt_drv) |-> ##[1:1000] !tgt_drv)
      else $error("target held sda too long");
   // only one party owns the data line at a sampling edge
   chk_one_owner: assert property (scl_up |-> !(ctl_drv && tgt_drv))
      else $error("both ends pulled sda at scl rise");
endmodule

// ==== verification/i2c_paged_control_port_checksum_bench.sv ====
// bench: controller end talks to target end over the link, checksums judged here
// assumes the package, link interface and both ends are compiled first
`timescale 1ns/1ns
module i2c_paged_control_port_checksum_bench;
   import ipc_pkg::*;
   localparam int LIMIT = 90000;
   logic clk_i = 1'b0;
   logic reset_i = 1'b1;
   logic [3:0] addr_r = 4'h0;
   logic [7:0] wdata_r = 8'h00;
   logic wr_r = 1'b0;
   logic rd_r = 1'b0;
   logic [1:0] strap_r = 2'h0;
   logic [7:0] rdata, page, book, crc, xr, wa, wd, last_addr, last_data;
   logic wstb;
   logic [6:0] tgt = {IPC_ADDR_HI, 2'h2};
   int fail_count = 0;
   int tests_run = 0;
   int cyc = 0;

   ipc_link_if ipc_link_if_i ();
   ipc_ctrl ipc_ctrl_i (.clk_i(clk_i), .reset_i(reset_i), .addr_i(addr_r), .wdata_i(wdata_r),
      .wr_i(wr_r), .rd_i(rd_r), .rdata_o(rdata), .link(ipc_link_if_i.ctl));
   ipc_target ipc_target_i (.clk_i(clk_i), .reset_i(reset_i), .addr_strap_i(strap_r),
      .link(ipc_link_if_i.tgt), .page_o(page), .book_o(book), .crc_o(crc), .xor_o(xr),
      .wr_stb_o(wstb), .wr_addr_o(wa), .wr_data_o(wd));
   ipc_link_chk ipc_link_chk_i (.clk_i(clk_i), .reset_i(reset_i), .scl(ipc_link_if_i.scl),
      .sda(ipc_link_if_i.sda), .scl_oe_ctl(ipc_link_if_i.scl_oe_ctl),
      .sda_oe_ctl(ipc_link_if_i.sda_oe_ctl), .sda_o_tgt(ipc_link_if_i.sda_o_tgt),
      .sda_oe_tgt(ipc_link_if_i.sda_oe_tgt));

   // 10 MHz system clock
   initial begin
      forever #50 clk_i = ~clk_i;
   end

   // last written byte seen by the system, and the hang limit
   always @(posedge clk_i) begin
      cyc <= cyc + 1;
      if (wstb === 1'b1) begin
         last_addr <= wa;
         last_data <= wd;
      end
      if (cyc == LIMIT) begin
         fail_count = fail_count + 1;
         $display("wrong value at %0t: cycle limit reached", $time);
         finish_test();
      end
   end

   task automatic finish_test();
      $display("checks %0d, mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
      tests_run = tests_run + 1;
      if (got !== exp) begin
         fail_count = fail_count + 1;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // msb-first crc step, no reflection, no final inversion
   function automatic logic [7:0] crc_step(input logic [7:0] c, input logic [7:0] b);
      logic [7:0] x;
      x = c ^ b;
      for (int i = 0; i < 8; i++) begin
         x = x[7] ? ((x << 1) ^ IPC_CRC_POLY) : (x << 1);
      end
      return x;
   endfunction

   // software port cycles: one-cycle strobes, read data the cycle after
   task automatic sw_wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk_i);
      addr_r <= a;
      wdata_r <= d;
      wr_r <= 1'b1;
      @(posedge clk_i);
      wr_r <= 1'b0;
   endtask
   task automatic sw_rd(input logic [3:0] a, output logic [7:0] d);
      @(posedge clk_i);
      addr_r <= a;
      rd_r <= 1'b1;
      @(posedge clk_i);
      rd_r <= 1'b0;
      @(posedge clk_i);
      d = rdata;
   endtask

   // one single-byte transfer, waits on busy under a bound
   task automatic xfer(input logic [6:0] t, input logic [7:0] sub, input logic [7:0] d,
      input logic rd, output logic [7:0] q, output logic nack);
      logic [7:0] st;
      int n;
      sw_wr(IPC_CMD_ADDR, {1'b0, t});
      sw_wr(IPC_CMD_SUB, sub);
      sw_wr(IPC_CMD_DATA, d);
      sw_wr(IPC_CMD_GO, {7'h00, rd});
      n = 0;
      st = 8'h01;
      while (st[0] !== 1'b0 && n < 20000) begin
         sw_rd(IPC_CMD_STAT, st);
         n = n + 1;
      end
      if (n >= 20000) begin
         fail_count = fail_count + 1;
         $display("wrong value at %0t: transfer never finished", $time);
      end
      nack = st[1];
      sw_rd(IPC_CMD_RDATA, q);
   endtask
   task automatic wr(input logic [7:0] sub, input logic [7:0] d);
      logic [7:0] q;
      logic nk;
      xfer(tgt, sub, d, 1'b0, q, nk);
      chk8({7'h00, nk}, 8'h00);
   endtask
   task automatic rd_chk(input logic [7:0] sub, input logic [7:0] exp);
      logic [7:0] q;
      logic nk;
      xfer(tgt, sub, 8'h00, 1'b1, q, nk);
      chk8(q, exp);
   endtask

   // each strap value moves the address; near misses go unanswered
   task automatic test_strap();
      logic [7:0] q;
      logic nk;
      for (int s = 0; s < 4; s++) begin
         strap_r <= 2'(s);
         xfer({IPC_ADDR_HI, 2'(s)}, IPC_REG_PAGE, 8'(s + 1), 1'b0, q, nk);
         chk8({7'h00, nk}, 8'h00);
         chk8(page, 8'(s + 1));
         q = s[0] ? {1'b0, IPC_ADDR_HI ^ 5'h04, 2'(s)} : {1'b0, IPC_ADDR_HI, 2'(s ^ 1)};
         xfer(q[6:0], IPC_REG_PAGE, 8'hee, 1'b0, q, nk);
         chk8({7'h00, nk}, 8'h01);
         chk8(page, 8'(s + 1));
      end
      strap_r <= 2'h2;
   endtask

   // book switch through page 0, then both start values loaded
   task automatic test_book();
      wr(IPC_REG_PAGE, IPC_PAGE_ZERO);
      wr(IPC_REG_BOOK, IPC_BOOK_CSUM);
      chk8(book, IPC_BOOK_CSUM);
      chk8(crc, 8'h00);
      wr(IPC_REG_XOR, 8'h33);
      chk8(xr, 8'h33);
      chk8(crc, crc_step(8'h00, 8'h33));
      wr(IPC_REG_CRC, 8'h5c);
      chk8(crc, 8'h5c);
   endtask

   // running sums over page 0, page 1, reads and another book
   task automatic test_csum();
      logic [7:0] c;
      logic [7:0] x;
      c = crc_step(8'h5c, 8'ha5);
      x = 8'h33;
      wr(8'h20, 8'ha5);
      chk8(crc, c);
      chk8(xr, x);
      wr(IPC_REG_PAGE, 8'h01);
      chk8(page, 8'h01);
      chk8(crc, c);
      wr(8'h10, 8'h3c);
      wr(8'h11, 8'h96);
      c = crc_step(crc_step(c, 8'h3c), 8'h96);
      x = x ^ 8'h3c ^ 8'h96;
      chk8(crc, c);
      chk8(xr, x);
      chk8(last_addr, 8'h11);
      chk8(last_data, 8'h96);
      rd_chk(8'h10, 8'h00);
      chk8(crc, c);
      chk8(xr, x);
      wr(IPC_REG_PAGE, IPC_PAGE_ZERO);
      rd_chk(IPC_REG_XOR, x);
      rd_chk(IPC_REG_CRC, c);
      rd_chk(IPC_REG_BOOK, IPC_BOOK_CSUM);
      wr(IPC_REG_BOOK, IPC_BOOK_BIQUAD);
      chk8(book, IPC_BOOK_BIQUAD);
      wr(8'h18, 8'h08);
      chk8(crc, crc_step(c, 8'h08));
      chk8(xr, x);
   endtask

   // main sequence
   initial begin
      repeat (5) @(posedge clk_i);
      reset_i <= 1'b0;
      test_strap();
      test_book();
      test_csum();
      finish_test();
   end
endmodule
